// ---- include/gfm_consts.vh ----
// constants for the general purpose pin function mapping block
// assumes a byte wide register port and a 128 entry control and status table
`ifndef GFM_CONSTS_VH
`define GFM_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define GFM_PIN7_FUNC_ADDR  8'hE7
`define GFM_PIN8_FUNC_ADDR  8'hE8
`define GFM_PIN9_FUNC_ADDR  8'hE9
`define GFM_PIN10_FUNC_ADDR 8'hEA
`define GFM_PIN11_FUNC_ADDR 8'hEB

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define GFM_INDEX_MSB       6
`define GFM_INDEX_LSB       0
`define GFM_INDEX_WIDTH     7
`define GFM_DIR_BIT         7
`define GFM_DIR_CONTROL     1'h0
`define GFM_DIR_STATUS      1'h1
`define GFM_FUNC_RESET      8'h00
`define GFM_FUNC_UNUSED     8'h00
`define GFM_TABLE_SIZE      128
`define GFM_UNMAPPED_READ   8'h00
`define GFM_NO_SLOT         3'h7

`endif

// ---- rtl/gfm_pin_slot.v ----
// one pin's function register and its direction and drive logic
// assumes the top decodes the address and passes a write strobe per slot
`timescale 1ns/1ps
`default_nettype none
`include "gfm_consts.vh"

module gfm_pin_slot #(
  parameter TABLE_SIZE = `GFM_TABLE_SIZE
) (
  input  wire                          sys_clk,
  input  wire                          reset,
  input  wire                          wr_en,
  input  wire [7:0]                    wr_data,
  input  wire [TABLE_SIZE-1:0]         status_table,
  output reg  [7:0]                    func_ff,
  output reg                           pin_out_ff,
  output reg                           pin_oe_n_ff,
  output wire                          ctrl_en,
  output wire [`GFM_INDEX_WIDTH-1:0]   table_index
);

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire direction_select;
  wire pin_used;

  assign table_index      = func_ff[`GFM_INDEX_MSB:`GFM_INDEX_LSB];
  assign direction_select = func_ff[`GFM_DIR_BIT];
  // all-zero register means the pin is left alone
  assign pin_used         = (func_ff != `GFM_FUNC_UNUSED);
  assign ctrl_en          = pin_used && (direction_select == `GFM_DIR_CONTROL);

  // ----------------------------------------------------------------
  // function register
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      func_ff <= `GFM_FUNC_RESET;
    end else if (wr_en) begin
      func_ff <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // pin drive: registered so the pin never glitches on a remap
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      pin_out_ff  <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end else if (pin_used && (direction_select == `GFM_DIR_STATUS)) begin
      pin_out_ff  <= status_table[table_index];
      pin_oe_n_ff <= 1'b0;
    end else begin
      pin_out_ff  <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/gfm_top.v ----
// pin function mapping for general purpose pins 7 to 11
// assumes a synchronous byte register port, pins synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "gfm_consts.vh"

module gfm_top #(
  parameter PIN_COUNT  = 5,
  parameter TABLE_SIZE = `GFM_TABLE_SIZE
) (
  input  wire                   sys_clk,
  input  wire                   reset,
  // register port
  input  wire [7:0]             reg_addr,
  input  wire                   reg_wr_en,
  input  wire [7:0]             reg_wr_data,
  input  wire                   reg_rd_en,
  output reg  [7:0]             reg_rd_data_ff,
  output reg                    reg_rd_valid_ff,
  output reg                    reg_addr_err_ff,
  // tables
  input  wire [TABLE_SIZE-1:0]  status_table,
  output reg  [TABLE_SIZE-1:0]  ctrl_table_ff,
  output reg  [TABLE_SIZE-1:0]  ctrl_update_ff,
  // pins, bit 0 is pin 7
  input  wire [PIN_COUNT-1:0]   pin_in,
  output wire [PIN_COUNT-1:0]   pin_out,
  output wire [PIN_COUNT-1:0]   pin_oe_n
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function [2:0] slot_of;
    input [7:0] addr;
    begin
      case (addr)
        `GFM_PIN7_FUNC_ADDR: begin
          slot_of = 3'h0;
        end
        `GFM_PIN8_FUNC_ADDR: begin
          slot_of = 3'h1;
        end
        `GFM_PIN9_FUNC_ADDR: begin
          slot_of = 3'h2;
        end
        `GFM_PIN10_FUNC_ADDR: begin
          slot_of = 3'h3;
        end
        `GFM_PIN11_FUNC_ADDR: begin
          slot_of = 3'h4;
        end
        default: begin
          slot_of = `GFM_NO_SLOT;
        end
      endcase
    end
  endfunction

  wire [2:0] addr_slot;
  wire       addr_hit;

  assign addr_slot = slot_of(reg_addr);
  assign addr_hit  = (addr_slot != `GFM_NO_SLOT);

  // ----------------------------------------------------------------
  // per pin slots
  // ----------------------------------------------------------------
  wire [PIN_COUNT*8-1:0]                 func_bus;
  wire [PIN_COUNT-1:0]                   slot_ctrl_en;
  wire [PIN_COUNT*`GFM_INDEX_WIDTH-1:0]  slot_index;

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_slot
      wire slot_wr;
      // widen the slot number instead of slicing the genvar
      assign slot_wr = reg_wr_en && addr_hit && ({29'h0, addr_slot} == g);
      gfm_pin_slot #(
        .TABLE_SIZE (TABLE_SIZE)
      ) u_slot (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .wr_en        (slot_wr),
        .wr_data      (reg_wr_data),
        .status_table (status_table),
        .func_ff      (func_bus[g*8 +: 8]),
        .pin_out_ff   (pin_out[g]),
        .pin_oe_n_ff  (pin_oe_n[g]),
        .ctrl_en      (slot_ctrl_en[g]),
        .table_index  (slot_index[g*`GFM_INDEX_WIDTH +: `GFM_INDEX_WIDTH])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // control table
  // ----------------------------------------------------------------
  // pins are applied from the highest down, so where two pins point at
  // the same bit the lower numbered pin wins; unmapped bits keep their
  // last value so a remap does not disturb the device
  reg [TABLE_SIZE-1:0]       nxt_ctrl_table;
  reg [TABLE_SIZE-1:0]       nxt_ctrl_update;
  reg [`GFM_INDEX_WIDTH-1:0] loop_index;
  integer                    p;

  always @* begin
    nxt_ctrl_table  = ctrl_table_ff;
    nxt_ctrl_update = {TABLE_SIZE{1'b0}};
    loop_index      = {`GFM_INDEX_WIDTH{1'b0}};
    for (p = PIN_COUNT - 1; p >= 0; p = p - 1) begin
      loop_index = slot_index[p*`GFM_INDEX_WIDTH +: `GFM_INDEX_WIDTH];
      if (slot_ctrl_en[p]) begin
        nxt_ctrl_table[loop_index]  = pin_in[p];
        nxt_ctrl_update[loop_index] = 1'b1;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      ctrl_table_ff  <= {TABLE_SIZE{1'b0}};
      ctrl_update_ff <= {TABLE_SIZE{1'b0}};
    end else begin
      ctrl_table_ff  <= nxt_ctrl_table;
      ctrl_update_ff <= nxt_ctrl_update;
    end
  end

  // ----------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------
  // one cycle read latency; unmapped offsets read as zero and flag
  reg [7:0] nxt_rd_data;
  reg       nxt_addr_err;

  always @* begin
    nxt_rd_data  = `GFM_UNMAPPED_READ;
    nxt_addr_err = 1'b0;
    if (reg_rd_en || reg_wr_en) begin
      nxt_addr_err = !addr_hit;
    end
    if (reg_rd_en && addr_hit) begin
      nxt_rd_data = func_bus[addr_slot*8 +: 8];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rd_data_ff  <= 8'h00;
      reg_rd_valid_ff <= 1'b0;
      reg_addr_err_ff <= 1'b0;
    end else begin
      reg_rd_data_ff  <= nxt_rd_data;
      reg_rd_valid_ff <= reg_rd_en;
      reg_addr_err_ff <= nxt_addr_err;
    end
  end

endmodule
`default_nettype wire

// ---- dv/gfm_sva.sv ----
// checker for the pin function mapping block
// assumes it is bound into gfm_top
`timescale 1ns/1ps
`default_nettype none
module gfm_sva #(parameter PIN_COUNT = 5, parameter TABLE_SIZE = 128) (
  input wire logic                  sys_clk, reset, reg_wr_en, reg_rd_en,
  input wire logic [7:0]            reg_addr, reg_wr_data, reg_rd_data_ff,
  input wire logic                  reg_rd_valid_ff, reg_addr_err_ff,
  input wire logic [TABLE_SIZE-1:0] status_table, ctrl_table_ff, ctrl_update_ff,
  input wire logic [PIN_COUNT-1:0]  pin_in, pin_out, pin_oe_n
);
  // ----
  // shadow of the function registers
  // ----
  logic [7:0]            sh_ff [PIN_COUNT];
  logic [7:0]            rd_ff;
  logic [PIN_COUNT-1:0]  st_ff;
  logic [TABLE_SIZE-1:0] ctl_ff, upd_ff;
  wire  [7:0]            off = reg_addr - 8'hE7;
  wire                   hit = off < 8'h05;
  wire                   bad = (reg_rd_en || reg_wr_en) && !hit;
  always_ff @(posedge sys_clk) begin
    rd_ff <= sh_ff[off[2:0]];
    upd_ff <= '0;
    if (reset) begin
      ctl_ff <= '0;
      for (int i = 0; i < PIN_COUNT; i++) sh_ff[i] <= 8'h00;
    end else begin
      if (reg_wr_en && hit) sh_ff[off[2:0]] <= reg_wr_data;
      // descending, so the lower pin lands last and wins a shared bit
      for (int i = PIN_COUNT - 1; i >= 0; i--) begin
        if (!sh_ff[i][7] && sh_ff[i] != 8'h00) begin
          ctl_ff[sh_ff[i][6:0]] <= pin_in[i];
          upd_ff[sh_ff[i][6:0]] <= 1'b1;
        end
      end
    end
    for (int i = 0; i < PIN_COUNT; i++) st_ff[i] <= status_table[sh_ff[i][6:0]];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_rd_valid: assert property (reg_rd_valid_ff == $past(reg_rd_en))
    else $error("read valid timing wrong");
  a_addr_err: assert property (reg_addr_err_ff == $past(bad))
    else $error("address error flag wrong");
  a_rd_data: assert property (reg_rd_en && hit |=> reg_rd_data_ff == rd_ff)
    else $error("read data wrong");
  a_ctrl_table: assert property (ctrl_table_ff == ctl_ff)
    else $error("control table wrong");
  a_ctrl_upd: assert property (ctrl_update_ff == upd_ff)
    else $error("control update wrong");
  a_idle_low: assert property ((pin_out & pin_oe_n) == '0)
    else $error("released pin not low");
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    a_stat_drive: assert property (
      sh_ff[g][7] |=> !pin_oe_n[g] && pin_out[g] == st_ff[g])
      else $error("status pin drive wrong");
    a_no_drive: assert property (!sh_ff[g][7] |=> pin_oe_n[g])
      else $error("pin driven outside status");
  end
  c_stat: cover property (!pin_oe_n[0]);
  c_ctrl: cover property (|ctrl_update_ff);
  c_err: cover property (reg_addr_err_ff);
endmodule
bind gfm_top gfm_sva #(.PIN_COUNT(PIN_COUNT), .TABLE_SIZE(TABLE_SIZE)) u_gfm_sva (.*);
`default_nettype wire

// ---- dv/gfm_board.sv ----
// board logic on pins 7 to 11
// assumes bit 0 is pin 7; the board lets go where the device drives
`timescale 1ns/1ps
`default_nettype none
module gfm_board (
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe_n,
  input  wire logic [4:0] board_lvl,
  output wire logic [4:0] pin_in
);
  assign pin_in = (pin_out & ~pin_oe_n) | (board_lvl & pin_oe_n);
endmodule
`default_nettype wire

// ---- dv/gfm_top_tb.sv ----
// testbench for the pin function mapping block
// assumes the checker binds itself and the board model sits on the pins
`timescale 1ns/1ps
`default_nettype none
module gfm_top_tb;
  logic         sys_clk = 1'b0, reset = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [7:0]   reg_addr = 8'h00, reg_wr_data = 8'h00;
  logic [127:0] status_table = '0;
  logic [4:0]   board_lvl = 5'h00;
  wire  [7:0]   reg_rd_data_ff;
  wire          reg_rd_valid_ff, reg_addr_err_ff;
  wire  [127:0] ctrl_table_ff, ctrl_update_ff;
  wire  [4:0]   pin_in, pin_out, pin_oe_n;
  int           fail_count = 0, check_count = 0;
  logic [7:0]   vals [5] = '{8'hFF, 8'h80, 8'h05, 8'h7F, 8'h85};
  always #25 sys_clk = ~sys_clk;
  gfm_top u_gfm_top (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data_ff(reg_rd_data_ff), .reg_rd_valid_ff(reg_rd_valid_ff),
    .reg_addr_err_ff(reg_addr_err_ff), .status_table(status_table),
    .ctrl_table_ff(ctrl_table_ff), .ctrl_update_ff(ctrl_update_ff), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  gfm_board u_gfm_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_lvl(board_lvl),
    .pin_in(pin_in));
  task automatic chk(input string what, input logic [127:0] exp, got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, exp, input logic err);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk("valid", 1'b1, reg_rd_valid_ff);
    chk("data", exp, reg_rd_data_ff);
    chk("err", err, reg_addr_err_ff);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a wedged run must still reach the verdict
  initial begin
    #20000;
    fail_count++;
    finish_test;
  end
  initial begin
    step(4);
    reset = 1'b0;
    board_lvl = 5'h1F;
    step(3);
    chk("oe_n", 5'h1F, pin_oe_n);
    chk("ctrl", '0, ctrl_table_ff | ctrl_update_ff);
    for (int p = 0; p < 5; p++) rd(8'hE7 + p[7:0], 8'h00, 1'b0);
    $display("test defaults done");
    for (int p = 0; p < 5; p++) wr(8'hE7 + p[7:0], vals[p]);
    wr(8'hE6, 8'hFF);
    chk("werr", 1'b1, reg_addr_err_ff);
    wr(8'hEC, 8'hFF);
    chk("werr", 1'b1, reg_addr_err_ff);
    for (int p = 0; p < 5; p++) rd(8'hE7 + p[7:0], vals[p], 1'b0);
    rd(8'hE6, 8'h00, 1'b1);
    rd(8'hEC, 8'h00, 1'b1);
    $display("test registers done");
    status_table[127] = 1'b1;
    status_table[5] = 1'b1;
    step(2);
    chk("stat", 5'h11, pin_out);
    chk("oe_n", 5'h0C, pin_oe_n);
    status_table = 128'h1;
    step(2);
    chk("stat", 5'h02, pin_out);
    $display("test status done");
    board_lvl = 5'h04;
    step(2);
    chk("ctrl", 2'b01, {ctrl_table_ff[127], ctrl_table_ff[5]});
    chk("upd", (128'h1 << 127) | 128'h20, ctrl_update_ff);
    board_lvl = 5'h10;
    step(2);
    chk("ctrl", '0, ctrl_table_ff);
    wr(8'hE9, 8'h00);
    board_lvl = 5'h1F;
    step(2);
    chk("ctrl", 128'h1 << 127, ctrl_table_ff);
    wr(8'hE9, 8'h7F);
    board_lvl = 5'h08;
    step(2);
    chk("ctrl", 1'b0, ctrl_table_ff[127]);
    $display("test control done");
    // reset again while pins are still mapped and driving
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    chk("oe_n", 5'h1F, pin_oe_n);
    chk("ctrl", '0, ctrl_table_ff | ctrl_update_ff);
    for (int p = 0; p < 5; p++) rd(8'hE7 + p[7:0], 8'h00, 1'b0);
    $display("test reset done");
    finish_test;
  end
endmodule
`default_nettype wire
